//--- hdl/tmr_pkg.sv
// Constants, source map and shared functions of the triggered measurement recorder
package tmr_pkg;

    // Sizes of a recording
    localparam int VAL_W = 16;
    localparam int NUM_CH = 8;
    localparam int DEPTH = 12;
    localparam int IDX_W = 4;
    localparam int CNT_W = 4;
    localparam int SRC_W = 8;
    localparam int FT_W = 3;
    localparam int NUM_STAGES = 15;
    localparam int STAGE_W = 4;
    localparam int REC_W = NUM_CH * VAL_W;

    // Source index map, grouped by what the source is derived from
    // Fundamental RMS IL1..I02 (0..4), true RMS (5..9), I1/I2/I0Z (10..12),
    // calculated residual (13), current angles (14..21)
    localparam logic [SRC_W-1:0] SRC_CUR_FIRST = 8'h00;
    localparam logic [SRC_W-1:0] SRC_PH1_TRUE_RMS = 8'h05;
    localparam logic [SRC_W-1:0] SRC_CALC_RESIDUAL = 8'h0d;
    // Voltage magnitudes (22..31), voltage angles (32..41)
    localparam logic [SRC_W-1:0] SRC_VOLT_FIRST = 8'h16;
    // Powers (42..61), impedances and admittances (62..107)
    localparam logic [SRC_W-1:0] SRC_MIXED_FIRST = 8'h2a;
    localparam logic [SRC_W-1:0] SRC_3PH_APPARENT = 8'h2a;
    // Frequencies, thermal models, internal and external sensors (108..131)
    localparam logic [SRC_W-1:0] SRC_OTHER_FIRST = 8'h6c;
    localparam logic [SRC_W-1:0] NUM_SRC = 8'h84;
    localparam int MEAS_W = 132 * VAL_W;

    // Trigger selection
    localparam logic TRIG_BREAKER = 1'b0;
    localparam logic TRIG_USER = 1'b1;

    // Fault type and stage code meaning "none recorded"
    localparam logic [FT_W-1:0] FT_NONE = 3'h0;
    localparam logic [STAGE_W-1:0] STAGE_NONE = 4'h0;

    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'hc;

    // A source is usable only if the variant has the inputs it is derived from
    function automatic logic src_allowed(input logic [SRC_W-1:0] src,
                                         input logic has_cur,
                                         input logic has_volt);
        logic ok;
        ok = 1'b0;
        if (src < SRC_VOLT_FIRST) begin
            ok = has_cur;
        end else if (src < SRC_MIXED_FIRST) begin
            ok = has_volt;
        end else if (src < SRC_OTHER_FIRST) begin
            ok = has_cur & has_volt;
        end else if (src < NUM_SRC) begin
            ok = has_cur | has_volt;
        end
        return ok;
    endfunction

    // Slot that follows a slot in the circular store
    function automatic logic [IDX_W-1:0] slot_inc(input logic [IDX_W-1:0] s);
        return (s == CNT_FULL - CNT_ONE) ? CNT_ZERO : s + CNT_ONE;
    endfunction

    // Slot lying a given distance behind a slot in the circular store
    function automatic logic [IDX_W-1:0] slot_back(input logic [IDX_W-1:0] s,
                                                   input logic [IDX_W-1:0] d);
        logic [IDX_W:0] t;
        t = {1'b0, s} + {1'b0, CNT_FULL} - {1'b0, d};
        if (t >= {1'b0, CNT_FULL}) begin
            t = t - {1'b0, CNT_FULL};
        end
        return t[IDX_W-1:0];
    endfunction

endpackage

//--- hdl/tmr_src_mux.sv
// One recording channel: picks a selected measurement in the chosen unit
`timescale 1ns/10ps
module tmr_src_mux
    import tmr_pkg::*;
(
    // Measurements of all sources
    input wire logic [MEAS_W-1:0] meas_pu,
    input wire logic [MEAS_W-1:0] meas_pri,
    // Channel configuration
    input wire logic [SRC_W-1:0] sel,
    input wire logic use_primary,
    input wire logic has_current_inputs,
    input wire logic has_voltage_inputs,
    // Selected value
    output logic [VAL_W-1:0] value,
    output logic valid
);

    always_comb begin
        value = '0;
        // (R13) Variant restricts sources
        valid = src_allowed(sel, has_current_inputs, has_voltage_inputs);
        // (R14) (R15) (R16) (R17) (R18) (R19) Whole source map
        if (valid) begin
            // (R3) Per-unit or primary
            if (use_primary) begin
                value = meas_pri[sel*VAL_W +: VAL_W];
            end else begin
                value = meas_pu[sel*VAL_W +: VAL_W];
            end
        end
    end

endmodule

//--- hdl/tmr_recorder.sv
// Triggered measurement recorder with circular store, fault display and report outputs
// Operation
// (R1) Trigger captures all selected magnitudes together
// (R2) Breaker trip or user trigger starts capture
// (R3) Setting picks per-unit or primary values
// (R4) Optional overcurrent and voltage fault types; the fault display shows them unmasked whatever the enables
// (R5) Capture on trigger edge, no delay
// (R6) Up to eight channels, one source each
// (R7) Twelve latest recordings readable locally
// (R8) Thirteenth capture overwrites the oldest
// (R9) Listed stage trip shows fault display
// (R10) Display shown only when enable set
// (R11) Chosen reset input clears displayed values
// (R12) Stage and fault types go to supervisory
// (R13) Variant limits sources to available inputs
// (R14) Fundamental and true RMS currents selectable
// (R15) Sequence, calculated residual, current angles selectable
// (R16) Voltage magnitudes and angles selectable
// (R17) Powers, tangent and cosine selectable
// (R18) Impedances and admittances with angles selectable
// (R19) Frequencies and temperature channels selectable
`timescale 1ns/10ps
module tmr_recorder
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration
    input wire logic trig_sel,
    input wire logic use_primary,
    input wire logic oc_type_en,
    input wire logic volt_type_en,
    input wire logic fault_view_display_enable,
    input wire logic [NUM_CH*SRC_W-1:0] ch_sel,
    input wire logic [NUM_CH-1:0] ch_en,
    input wire logic has_current_inputs,
    input wire logic has_voltage_inputs,
    // Trigger and protection inputs
    input wire logic breaker_trip,
    input wire logic user_trigger,
    input wire logic [NUM_STAGES-1:0] stage_trip,
    input wire logic [FT_W-1:0] oc_fault_type,
    input wire logic [FT_W-1:0] volt_fault_type,
    input wire logic fault_reset,
    // Measurements
    input wire logic [MEAS_W-1:0] meas_pu,
    input wire logic [MEAS_W-1:0] meas_pri,
    // Local readout, index 0 is the newest recording
    input wire logic [IDX_W-1:0] rd_index,
    output logic [CNT_W-1:0] rec_count,
    output logic rd_present,
    output logic [REC_W-1:0] rd_values,
    output logic [NUM_CH-1:0] rd_valid,
    output logic rd_primary,
    output logic [STAGE_W-1:0] rd_stage,
    output logic [FT_W-1:0] rd_oc_type,
    output logic [FT_W-1:0] rd_volt_type,
    // Fault display
    output logic disp_active,
    output logic [REC_W-1:0] disp_values,
    output logic [STAGE_W-1:0] disp_stage,
    output logic [FT_W-1:0] disp_oc_type,
    output logic [FT_W-1:0] disp_volt_type,
    // Supervisory report
    output logic rep_strobe,
    output logic [STAGE_W-1:0] rep_stage,
    output logic [FT_W-1:0] rep_oc_type,
    output logic [FT_W-1:0] rep_volt_type
);

    // Stage code: lowest numbered tripping stage, one based
    function automatic logic [STAGE_W-1:0] stage_code(input logic [NUM_STAGES-1:0] t);
        logic [STAGE_W-1:0] c;
        c = STAGE_NONE;
        for (int i = NUM_STAGES - 1; i >= 0; i--) begin
            if (t[i]) begin
                c = STAGE_W'(i + 1);
            end
        end
        return c;
    endfunction

    // Live channel values
    logic [REC_W-1:0] live_val;
    logic [NUM_CH-1:0] live_ok;

    // (R6) Eight channel selectors
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        tmr_src_mux u_mux (
            .meas_pu(meas_pu),
            .meas_pri(meas_pri),
            .sel(ch_sel[g*SRC_W +: SRC_W]),
            .use_primary(use_primary),
            .has_current_inputs(has_current_inputs),
            .has_voltage_inputs(has_voltage_inputs),
            .value(live_val[g*VAL_W +: VAL_W]),
            .valid(live_ok[g])
        );
    end

    logic [NUM_CH-1:0] live_valid;
    logic [REC_W-1:0] live_rec;
    logic trig_now;
    logic capture;
    logic [STAGE_W-1:0] live_stage;
    logic [FT_W-1:0] live_oc;
    logic [FT_W-1:0] live_volt;

    // Trigger edge state
    logic trig_prev_reg, trig_prev_next;
    logic [NUM_STAGES-1:0] stage_prev_reg, stage_prev_next;

    always_comb begin
        live_valid = live_ok & ch_en;
        // Disabled channels read zero, never a stale source value
        for (int k = 0; k < NUM_CH; k++) begin
            live_rec[k*VAL_W +: VAL_W] = live_valid[k] ? live_val[k*VAL_W +: VAL_W] : '0;
        end
        // (R2) Trigger source select
        trig_now = (trig_sel == TRIG_USER) ? user_trigger : breaker_trip;
        // (R5) Capture on the rising edge itself
        capture = trig_now & ~trig_prev_reg;
        live_stage = stage_code(stage_trip);
        // (R4) Fault types only when enabled, for the store and the report; the fault display takes them unmasked
        live_oc = oc_type_en ? oc_fault_type : FT_NONE;
        live_volt = volt_type_en ? volt_fault_type : FT_NONE;
        trig_prev_next = trig_now;
        stage_prev_next = stage_trip;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trig_prev_reg <= 1'b0;
            stage_prev_reg <= '0;
        end else begin
            trig_prev_reg <= trig_prev_next;
            stage_prev_reg <= stage_prev_next;
        end
    end

    // Circular store of recordings
    logic [REC_W-1:0] st_val_reg [DEPTH];
    logic [REC_W-1:0] st_val_next [DEPTH];
    logic [NUM_CH-1:0] st_ok_reg [DEPTH];
    logic [NUM_CH-1:0] st_ok_next [DEPTH];
    logic [DEPTH-1:0] st_pri_reg, st_pri_next;
    logic [STAGE_W-1:0] st_stage_reg [DEPTH];
    logic [STAGE_W-1:0] st_stage_next [DEPTH];
    logic [FT_W-1:0] st_oc_reg [DEPTH];
    logic [FT_W-1:0] st_oc_next [DEPTH];
    logic [FT_W-1:0] st_volt_reg [DEPTH];
    logic [FT_W-1:0] st_volt_next [DEPTH];
    logic [IDX_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;

    always_comb begin
        st_val_next = st_val_reg;
        st_ok_next = st_ok_reg;
        st_pri_next = st_pri_reg;
        st_stage_next = st_stage_reg;
        st_oc_next = st_oc_reg;
        st_volt_next = st_volt_reg;
        wr_ptr_next = wr_ptr_reg;
        count_next = count_reg;
        if (capture) begin
            // (R1) Whole snapshot in one slot
            st_val_next[wr_ptr_reg] = live_rec;
            st_ok_next[wr_ptr_reg] = live_valid;
            st_pri_next[wr_ptr_reg] = use_primary;
            st_stage_next[wr_ptr_reg] = live_stage;
            st_oc_next[wr_ptr_reg] = live_oc;
            st_volt_next[wr_ptr_reg] = live_volt;
            // (R8) Pointer wraps over the oldest
            wr_ptr_next = slot_inc(wr_ptr_reg);
            // (R7) Count saturates at twelve
            if (count_reg != CNT_FULL) begin
                count_next = count_reg + CNT_ONE;
            end
        end
    end

    // Recording payload apart from st_pri_reg has no reset: only slots below the count are ever shown
    always_ff @(posedge clk_sys) begin
        st_val_reg <= st_val_next;
        st_ok_reg <= st_ok_next;
        st_stage_reg <= st_stage_next;
        st_oc_reg <= st_oc_next;
        st_volt_reg <= st_volt_next;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_pri_reg <= '0;
            wr_ptr_reg <= CNT_ZERO;
            count_reg <= CNT_ZERO;
        end else begin
            st_pri_reg <= st_pri_next;
            wr_ptr_reg <= wr_ptr_next;
            count_reg <= count_next;
        end
    end

    // Registered readout
    logic rd_present_reg, rd_present_next;
    logic [REC_W-1:0] rd_values_reg, rd_values_next;
    logic [NUM_CH-1:0] rd_valid_reg, rd_valid_next;
    logic rd_primary_reg, rd_primary_next;
    logic [STAGE_W-1:0] rd_stage_reg, rd_stage_next;
    logic [FT_W-1:0] rd_oc_reg, rd_oc_next;
    logic [FT_W-1:0] rd_volt_reg, rd_volt_next;
    logic [IDX_W-1:0] rd_slot;

    always_comb begin
        // Newest recording sits just behind the write pointer
        rd_slot = slot_back(wr_ptr_reg, rd_index + CNT_ONE);
        rd_present_next = 1'b0;
        rd_values_next = '0;
        rd_valid_next = '0;
        rd_primary_next = 1'b0;
        rd_stage_next = STAGE_NONE;
        rd_oc_next = FT_NONE;
        rd_volt_next = FT_NONE;
        // (R7) Any of the held recordings
        if (rd_index < count_reg) begin
            rd_present_next = 1'b1;
            rd_values_next = st_val_reg[rd_slot];
            rd_valid_next = st_ok_reg[rd_slot];
            rd_primary_next = st_pri_reg[rd_slot];
            rd_stage_next = st_stage_reg[rd_slot];
            rd_oc_next = st_oc_reg[rd_slot];
            rd_volt_next = st_volt_reg[rd_slot];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_present_reg <= 1'b0;
            rd_values_reg <= '0;
            rd_valid_reg <= '0;
            rd_primary_reg <= 1'b0;
            rd_stage_reg <= STAGE_NONE;
            rd_oc_reg <= FT_NONE;
            rd_volt_reg <= FT_NONE;
        end else begin
            rd_present_reg <= rd_present_next;
            rd_values_reg <= rd_values_next;
            rd_valid_reg <= rd_valid_next;
            rd_primary_reg <= rd_primary_next;
            rd_stage_reg <= rd_stage_next;
            rd_oc_reg <= rd_oc_next;
            rd_volt_reg <= rd_volt_next;
        end
    end

    // Fault display
    logic disp_active_reg, disp_active_next;
    logic [REC_W-1:0] disp_values_reg, disp_values_next;
    logic [STAGE_W-1:0] disp_stage_reg, disp_stage_next;
    logic [FT_W-1:0] disp_oc_reg, disp_oc_next;
    logic [FT_W-1:0] disp_volt_reg, disp_volt_next;
    logic stage_rise;

    always_comb begin
        // (R9) New trip of any listed stage
        stage_rise = |(stage_trip & ~stage_prev_reg);
        disp_active_next = disp_active_reg;
        disp_values_next = disp_values_reg;
        disp_stage_next = disp_stage_reg;
        disp_oc_next = disp_oc_reg;
        disp_volt_next = disp_volt_reg;
        // (R11) Reset input clears the values
        if (fault_reset) begin
            disp_active_next = 1'b0;
            disp_values_next = '0;
            disp_stage_next = STAGE_NONE;
            disp_oc_next = FT_NONE;
            disp_volt_next = FT_NONE;
        end
        // (R10) Enable gates the view; a trip in the reset cycle still shows
        if (stage_rise && fault_view_display_enable) begin
            disp_active_next = 1'b1;
            disp_values_next = live_rec;
            disp_stage_next = live_stage;
            disp_oc_next = oc_fault_type;
            disp_volt_next = volt_fault_type;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            disp_active_reg <= 1'b0;
            disp_values_reg <= '0;
            disp_stage_reg <= STAGE_NONE;
            disp_oc_reg <= FT_NONE;
            disp_volt_reg <= FT_NONE;
        end else begin
            disp_active_reg <= disp_active_next;
            disp_values_reg <= disp_values_next;
            disp_stage_reg <= disp_stage_next;
            disp_oc_reg <= disp_oc_next;
            disp_volt_reg <= disp_volt_next;
        end
    end

    // Supervisory report, refreshed on every capture
    logic rep_strobe_reg, rep_strobe_next;
    logic [STAGE_W-1:0] rep_stage_reg, rep_stage_next;
    logic [FT_W-1:0] rep_oc_reg, rep_oc_next;
    logic [FT_W-1:0] rep_volt_reg, rep_volt_next;

    always_comb begin
        rep_strobe_next = capture;
        rep_stage_next = rep_stage_reg;
        rep_oc_next = rep_oc_reg;
        rep_volt_next = rep_volt_reg;
        // (R12) Forward stage and fault types
        if (capture) begin
            rep_stage_next = live_stage;
            rep_oc_next = live_oc;
            rep_volt_next = live_volt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rep_strobe_reg <= 1'b0;
            rep_stage_reg <= STAGE_NONE;
            rep_oc_reg <= FT_NONE;
            rep_volt_reg <= FT_NONE;
        end else begin
            rep_strobe_reg <= rep_strobe_next;
            rep_stage_reg <= rep_stage_next;
            rep_oc_reg <= rep_oc_next;
            rep_volt_reg <= rep_volt_next;
        end
    end

    assign rec_count = count_reg;
    assign rd_present = rd_present_reg;
    assign rd_values = rd_values_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_primary = rd_primary_reg;
    assign rd_stage = rd_stage_reg;
    assign rd_oc_type = rd_oc_reg;
    assign rd_volt_type = rd_volt_reg;
    assign disp_active = disp_active_reg;
    assign disp_values = disp_values_reg;
    assign disp_stage = disp_stage_reg;
    assign disp_oc_type = disp_oc_reg;
    assign disp_volt_type = disp_volt_reg;
    assign rep_strobe = rep_strobe_reg;
    assign rep_stage = rep_stage_reg;
    assign rep_oc_type = rep_oc_reg;
    assign rep_volt_type = rep_volt_reg;

endmodule

//--- sim/tmr_recorder_asserts.sv
// Concurrent checks on the recorder ports
`timescale 1ns/10ps
module tmr_recorder_chk
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Inputs watched
    input wire logic trig_sel,
    input wire logic breaker_trip,
    input wire logic user_trigger,
    input wire logic oc_type_en,
    input wire logic fault_view_display_enable,
    input wire logic [NUM_STAGES-1:0] stage_trip,
    input wire logic [FT_W-1:0] oc_fault_type,
    input wire logic fault_reset,
    input wire logic [IDX_W-1:0] rd_index,
    // Outputs watched
    input wire logic [CNT_W-1:0] rec_count,
    input wire logic rd_present,
    input wire logic disp_active,
    input wire logic [STAGE_W-1:0] disp_stage,
    input wire logic rep_strobe,
    input wire logic [FT_W-1:0] rep_oc_type
);
    logic trig_prev_reg;
    logic [NUM_STAGES-1:0] stage_prev_reg;
    logic trig_now;
    logic trip_rise;
    logic [STAGE_W-1:0] low_stage;

    assign trig_now = trig_sel ? user_trigger : breaker_trip;
    assign trip_rise = (|(stage_trip & ~stage_prev_reg)) && fault_view_display_enable;

    // Lowest set trip bit wins, so scan from the top down
    always_comb begin
        low_stage = STAGE_NONE;
        for (int i = NUM_STAGES - 1; i >= 0; i--) begin
            if (stage_trip[i]) begin
                low_stage = STAGE_W'(i + 1);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trig_prev_reg <= 1'b0;
            stage_prev_reg <= '0;
        end else begin
            trig_prev_reg <= trig_now;
            stage_prev_reg <= stage_trip;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_capture;
        trig_now && !trig_prev_reg;
    endsequence

    sequence s_trip;
        trip_rise;
    endsequence

    chk_capture_strobe: assert property (s_capture |=> rep_strobe)
        else $error("capture edge gave no report strobe");
    chk_no_spurious: assert property (!(trig_now && !trig_prev_reg) |=> !rep_strobe)
        else $error("report strobe without a trigger edge");
    chk_count_step: assert property (rep_strobe |-> rec_count == (($past(rec_count) == CNT_FULL)
        ? CNT_FULL : $past(rec_count) + CNT_ONE))
        else $error("recording count did not step on capture");
    chk_count_hold: assert property (!rep_strobe |-> $stable(rec_count))
        else $error("recording count moved without capture");
    chk_count_max: assert property (rec_count <= CNT_FULL)
        else $error("recording count above twelve");
    chk_oc_mask: assert property (rep_strobe |->
        rep_oc_type == ($past(oc_type_en) ? $past(oc_fault_type) : FT_NONE))
        else $error("reported overcurrent type wrong");
    chk_rd_present: assert property (rd_present == ($past(rd_index) < $past(rec_count)))
        else $error("readout presence flag wrong");
    chk_disp_show: assert property (s_trip |=> disp_active && disp_stage == $past(low_stage))
        else $error("fault display not raised with stage");
    chk_disp_gate: assert property ($rose(disp_active) |-> $past(fault_view_display_enable))
        else $error("fault display raised while disabled");
    chk_disp_clear: assert property (fault_reset && !trip_rise |=> !disp_active)
        else $error("fault display not cleared");
endmodule

bind tmr_recorder tmr_recorder_chk u_chk (.clk_sys(clk_sys), .rst(rst), .trig_sel(trig_sel),
    .breaker_trip(breaker_trip), .user_trigger(user_trigger), .oc_type_en(oc_type_en),
    .fault_view_display_enable(fault_view_display_enable), .stage_trip(stage_trip),
    .oc_fault_type(oc_fault_type), .fault_reset(fault_reset), .rd_index(rd_index),
    .rec_count(rec_count), .rd_present(rd_present), .disp_active(disp_active),
    .disp_stage(disp_stage), .rep_strobe(rep_strobe), .rep_oc_type(rep_oc_type));

//--- sim/tmr_field.sv
// Measurement source model: each source carries its index and a sample epoch
`timescale 1ns/10ps
module tmr_field
    import tmr_pkg::*;
(
    // Sample epoch chosen by the bench
    input wire logic [7:0] epoch,
    // Measurements of all sources
    output logic [MEAS_W-1:0] meas_pu,
    output logic [MEAS_W-1:0] meas_pri
);
    // Primary values carry the inverted epoch so a unit mix-up shows
    always_comb begin
        for (int s = 0; s < 132; s++) begin
            meas_pu[s*VAL_W +: VAL_W] = {epoch, 8'(s)};
            meas_pri[s*VAL_W +: VAL_W] = {~epoch, 8'(s)};
        end
    end
endmodule

//--- sim/testbench.sv
// Self-checking bench of the triggered measurement recorder
`timescale 1ns/10ps
module testbench;
    import tmr_pkg::*;
    logic clk_sys, rst, trig_sel, use_primary, oc_type_en, volt_type_en, fve;
    logic has_current_inputs, has_voltage_inputs, breaker_trip, user_trigger, fault_reset;
    logic [NUM_CH*SRC_W-1:0] ch_sel;
    logic [NUM_CH-1:0] ch_en, rd_valid;
    logic [NUM_STAGES-1:0] stage_trip;
    logic [FT_W-1:0] oc_fault_type, volt_fault_type, rd_oc_type, rd_volt_type;
    logic [FT_W-1:0] disp_oc_type, disp_volt_type, rep_oc_type, rep_volt_type;
    logic [MEAS_W-1:0] meas_pu, meas_pri;
    logic [IDX_W-1:0] rd_index;
    logic [CNT_W-1:0] rec_count, cnt;
    logic [REC_W-1:0] rd_values, disp_values;
    logic [STAGE_W-1:0] rd_stage, disp_stage, rep_stage;
    logic rd_present, rd_primary, disp_active, rep_strobe;
    logic [7:0] epoch;
    logic [7:0] hist[$];
    int fails = 0;
    int checks = 0;

    tmr_field u_field (.epoch(epoch), .meas_pu(meas_pu), .meas_pri(meas_pri));

    tmr_recorder u_dut (.fault_view_display_enable(fve), .*);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic ok_src(input int k);
        logic [7:0] s;
        s = ch_sel[8*k +: 8];
        if (s < SRC_VOLT_FIRST) return ch_en[k] & has_current_inputs;
        if (s < SRC_MIXED_FIRST) return ch_en[k] & has_voltage_inputs;
        if (s < SRC_OTHER_FIRST) return ch_en[k] & has_current_inputs & has_voltage_inputs;
        return ch_en[k] & (s < NUM_SRC) & (has_current_inputs | has_voltage_inputs);
    endfunction

    function automatic logic [REC_W-1:0] exp_rec(input logic [7:0] ep);
        logic [REC_W-1:0] r;
        r = '0;
        for (int k = 0; k < NUM_CH; k++) begin
            if (ok_src(k)) r[16*k +: 16] = {use_primary ? ~ep : ep, ch_sel[8*k +: 8]};
        end
        return r;
    endfunction

    function automatic logic [NUM_CH-1:0] exp_vld();
        logic [NUM_CH-1:0] v;
        for (int k = 0; k < NUM_CH; k++) v[k] = ok_src(k);
        return v;
    endfunction

    function automatic logic [STAGE_W-1:0] low_stg();
        for (int i = 0; i < NUM_STAGES; i++) begin
            if (stage_trip[i]) return STAGE_W'(i + 1);
        end
        return STAGE_NONE;
    endfunction

    task automatic chk(input logic [REC_W-1:0] got, input logic [REC_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Epoch moves after the trigger so a late snapshot shows
    task automatic capture(input logic [7:0] ep);
        logic [FT_W-1:0] eo, ev;
        eo = oc_type_en ? oc_fault_type : FT_NONE;
        ev = volt_type_en ? volt_fault_type : FT_NONE;
        @(negedge clk_sys);
        {epoch, rd_index, breaker_trip, user_trigger} = {ep, 4'h0, !trig_sel, trig_sel};
        @(negedge clk_sys);
        {epoch, breaker_trip, user_trigger} = {~ep, 2'b00};
        hist.push_front(ep);
        cnt = (cnt < CNT_FULL) ? cnt + CNT_ONE : cnt;
        chk(rep_strobe, 1'b1);
        chk(rec_count, cnt);
        chk(rep_oc_type, eo);
        chk(rep_volt_type, ev);
        chk(rep_stage, low_stg());
        @(negedge clk_sys);
        chk(rep_strobe, 1'b0);
        chk(rd_values, exp_rec(ep));
        chk(rd_valid, exp_vld());
        chk(rd_primary, use_primary);
        chk(rd_volt_type, ev);
        chk(rd_oc_type, eo);
        chk(rd_stage, low_stg());
    endtask

    task automatic readout(input logic [IDX_W-1:0] idx);
        @(negedge clk_sys);
        rd_index = idx;
        @(negedge clk_sys);
        chk(rd_present, idx < cnt);
        chk(rd_values, (idx < cnt) ? exp_rec(hist[idx]) : '0);
    endtask

    task automatic t_sources();
        chk(rec_count, CNT_ZERO);
        capture(8'h11);
        use_primary = 1'b1;
        ch_en = 8'h7e;
        capture(8'h22);
        has_voltage_inputs = 1'b0;
        capture(8'h33);
        has_current_inputs = 1'b0;
        has_voltage_inputs = 1'b1;
        capture(8'h44);
        has_current_inputs = 1'b1;
        ch_en = 8'hff;
    endtask

    task automatic t_select();
        int n;
        n = 0;
        trig_sel = TRIG_USER;
        @(negedge clk_sys);
        breaker_trip = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(rep_strobe, 1'b0);
        breaker_trip = 1'b0;
        capture(8'h55);
        epoch = 8'h56;
        user_trigger = 1'b1;
        repeat (5) begin
            @(negedge clk_sys);
            n += int'(rep_strobe === 1'b1);
        end
        user_trigger = 1'b0;
        hist.push_front(8'h56);
        cnt = (cnt < CNT_FULL) ? cnt + CNT_ONE : cnt;
        chk(n, 1);
        chk(rec_count, cnt);
        trig_sel = TRIG_BREAKER;
    endtask

    task automatic t_types();
        stage_trip = 15'h0104;
        oc_type_en = 1'b1;
        capture(8'h66);
        oc_type_en = 1'b0;
        volt_type_en = 1'b1;
        capture(8'h67);
        stage_trip = '0;
        for (int i = 0; i < 13; i++) capture(8'h70 + 8'(i));
        readout(4'h0);
        readout(4'hb);
        readout(4'hc);
    endtask

    task automatic t_display();
        @(negedge clk_sys);
        stage_trip = 15'h0010;
        repeat (2) @(negedge clk_sys);
        chk(disp_active, 1'b0);
        stage_trip = '0;
        fve = 1'b1;
        epoch = 8'h99;
        @(negedge clk_sys);
        stage_trip = 15'h4008;
        repeat (2) @(negedge clk_sys);
        chk(disp_active, 1'b1);
        chk(disp_stage, 4'h4);
        chk(disp_oc_type, oc_fault_type);
        chk(disp_volt_type, volt_fault_type);
        chk(disp_values, exp_rec(8'h99));
        fault_reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(disp_active, 1'b0);
        chk(disp_values, '0);
        fault_reset = 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        {trig_sel, use_primary, oc_type_en, volt_type_en, fve, fault_reset} = '0;
        {breaker_trip, user_trigger, stage_trip, rd_index, cnt} = '0;
        {has_current_inputs, has_voltage_inputs, ch_en} = {2'b11, 8'hff};
        ch_sel = {8'h83, SRC_OTHER_FIRST, 8'h3e, SRC_3PH_APPARENT, SRC_VOLT_FIRST,
                  SRC_CALC_RESIDUAL, SRC_PH1_TRUE_RMS, SRC_CUR_FIRST};
        oc_fault_type = 3'h5;
        volt_fault_type = 3'h6;
        epoch = 8'h00;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_sources();
        t_select();
        t_types();
        t_display();
        summarize();
    end

    // Whole run needs under a hundred cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        summarize();
    end
endmodule
